// [rtl/sfrm_pkg.sv]
// Notes on behaviour
// - Unimplemented register bits hold zero from reset and read back as zero.
// - At reset release the port 1 and port 2 latches load from the port reset level bit.
// - Reset clears the idle, power-down and both general flag bits of power control.
// - The brownout and power-on flags are untouched by system reset.
// - The power-on flag is set when power is first applied.
// - The brownout flag is set by a brownout event and when power is first applied.
// - Watchdog control reloads one of three values chosen by reset cause and watchdog enable.
// - Timer control, serial control, program status and ports 1 and 2 also take single-bit access.
package sfrm_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SP = 8'h81;
  localparam logic [7:0] ADDR_PORT0_OUTPUT_MODE_A = 8'h84;
  localparam logic [7:0] ADDR_PORT0_OUTPUT_MODE_B = 8'h85;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_TL0 = 8'h8a;
  localparam logic [7:0] ADDR_TL1 = 8'h8b;
  localparam logic [7:0] ADDR_TH0 = 8'h8c;
  localparam logic [7:0] ADDR_TH1 = 8'h8d;
  localparam logic [7:0] ADDR_P1 = 8'h90;
  localparam logic [7:0] ADDR_PORT1_OUTPUT_MODE_A = 8'h91;
  localparam logic [7:0] ADDR_PORT1_OUTPUT_MODE_B = 8'h92;
  localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] ADDR_P2 = 8'ha0;
  localparam logic [7:0] ADDR_PORT2_MODE_A_AND_MISC = 8'ha4;
  localparam logic [7:0] ADDR_PORT2_OUTPUT_MODE_B = 8'ha5;
  localparam logic [7:0] ADDR_WATCHDOG_FEED = 8'ha6;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'ha7;
  localparam logic [7:0] ADDR_SERIAL_OWN_ADDRESS = 8'ha9;
  localparam logic [7:0] ADDR_SERIAL_ADDRESS_MASK = 8'hb9;
  localparam logic [7:0] ADDR_PSW = 8'hd0;
  localparam logic [7:0] ADDR_PORT0_INPUT_DISABLE = 8'hf6;

  // ----------------------------------------------------------------
  // Storage slots
  // ----------------------------------------------------------------
  localparam int NUM_SLOTS = 24;
  localparam logic [4:0] SLOT_SP = 5'h00;
  localparam logic [4:0] SLOT_PORT0_OUTPUT_MODE_A = 5'h01;
  localparam logic [4:0] SLOT_PORT0_OUTPUT_MODE_B = 5'h02;
  localparam logic [4:0] SLOT_POWER_CONTROL = 5'h03;
  localparam logic [4:0] SLOT_TIMER_CONTROL = 5'h04;
  localparam logic [4:0] SLOT_TIMER_MODE = 5'h05;
  localparam logic [4:0] SLOT_TL0 = 5'h06;
  localparam logic [4:0] SLOT_TL1 = 5'h07;
  localparam logic [4:0] SLOT_TH0 = 5'h08;
  localparam logic [4:0] SLOT_TH1 = 5'h09;
  localparam logic [4:0] SLOT_P1 = 5'h0a;
  localparam logic [4:0] SLOT_PORT1_OUTPUT_MODE_A = 5'h0b;
  localparam logic [4:0] SLOT_PORT1_OUTPUT_MODE_B = 5'h0c;
  localparam logic [4:0] SLOT_SERIAL_CONTROL = 5'h0d;
  localparam logic [4:0] SLOT_SERIAL_BUFFER = 5'h0e;
  localparam logic [4:0] SLOT_P2 = 5'h0f;
  localparam logic [4:0] SLOT_PORT2_MODE_A_AND_MISC = 5'h10;
  localparam logic [4:0] SLOT_PORT2_OUTPUT_MODE_B = 5'h11;
  localparam logic [4:0] SLOT_WATCHDOG_FEED = 5'h12;
  localparam logic [4:0] SLOT_WATCHDOG_CONTROL = 5'h13;
  localparam logic [4:0] SLOT_SERIAL_OWN_ADDRESS = 5'h14;
  localparam logic [4:0] SLOT_SERIAL_ADDRESS_MASK = 5'h15;
  localparam logic [4:0] SLOT_PSW = 5'h16;
  localparam logic [4:0] SLOT_PORT0_INPUT_DISABLE = 5'h17;
  localparam logic [4:0] SLOT_NONE = 5'h1f;

  // ----------------------------------------------------------------
  // Values, masks and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] MASK_P1_MODE = 8'hd3;
  localparam logic [7:0] MASK_P2_LOW = 8'h03;
  localparam logic [7:0] MASK_WDOG = 8'h3f;
  localparam logic [7:0] MASK_POWER_CONTROL_CORE = 8'h0f;
  localparam int POWER_CONTROL_BOF_BIT = 5;
  localparam int POWER_CONTROL_POF_BIT = 4;
  localparam int PSW_PARITY_BIT = 0;
  localparam int TIMER_MODE_T1_LSB = 4;
  localparam int WATCHDOG_CONTROL_OVF_BIT = 5;
  localparam logic [7:0] WATCHDOG_CONTROL_DEF_WDRESET = 8'h30;
  localparam logic [7:0] WATCHDOG_CONTROL_DEF_ENABLED = 8'h10;
  localparam logic [7:0] WATCHDOG_CONTROL_DEF_DISABLED = 8'h00;

  // Phase of the block after reset release
  typedef enum logic {
    ST_INIT = 1'b0,
    ST_RUN = 1'b1
  } sfrm_phase_e;

  // Address to storage slot
  function automatic logic [4:0] slotOf(input logic [7:0] addr);
    unique case (addr)
      ADDR_SP: slotOf = SLOT_SP;
      ADDR_PORT0_OUTPUT_MODE_A: slotOf = SLOT_PORT0_OUTPUT_MODE_A;
      ADDR_PORT0_OUTPUT_MODE_B: slotOf = SLOT_PORT0_OUTPUT_MODE_B;
      ADDR_POWER_CONTROL: slotOf = SLOT_POWER_CONTROL;
      ADDR_TIMER_CONTROL: slotOf = SLOT_TIMER_CONTROL;
      ADDR_TIMER_MODE: slotOf = SLOT_TIMER_MODE;
      ADDR_TL0: slotOf = SLOT_TL0;
      ADDR_TL1: slotOf = SLOT_TL1;
      ADDR_TH0: slotOf = SLOT_TH0;
      ADDR_TH1: slotOf = SLOT_TH1;
      ADDR_P1: slotOf = SLOT_P1;
      ADDR_PORT1_OUTPUT_MODE_A: slotOf = SLOT_PORT1_OUTPUT_MODE_A;
      ADDR_PORT1_OUTPUT_MODE_B: slotOf = SLOT_PORT1_OUTPUT_MODE_B;
      ADDR_SERIAL_CONTROL: slotOf = SLOT_SERIAL_CONTROL;
      ADDR_SERIAL_BUFFER: slotOf = SLOT_SERIAL_BUFFER;
      ADDR_P2: slotOf = SLOT_P2;
      ADDR_PORT2_MODE_A_AND_MISC: slotOf = SLOT_PORT2_MODE_A_AND_MISC;
      ADDR_PORT2_OUTPUT_MODE_B: slotOf = SLOT_PORT2_OUTPUT_MODE_B;
      ADDR_WATCHDOG_FEED: slotOf = SLOT_WATCHDOG_FEED;
      ADDR_WATCHDOG_CONTROL: slotOf = SLOT_WATCHDOG_CONTROL;
      ADDR_SERIAL_OWN_ADDRESS: slotOf = SLOT_SERIAL_OWN_ADDRESS;
      ADDR_SERIAL_ADDRESS_MASK: slotOf = SLOT_SERIAL_ADDRESS_MASK;
      ADDR_PSW: slotOf = SLOT_PSW;
      ADDR_PORT0_INPUT_DISABLE: slotOf = SLOT_PORT0_INPUT_DISABLE;
      default: slotOf = SLOT_NONE;
    endcase
  endfunction : slotOf

  // Implemented bits of each slot
  function automatic logic [7:0] implMask(input logic [4:0] slot);
    unique case (slot)
      SLOT_PORT1_OUTPUT_MODE_A, SLOT_PORT1_OUTPUT_MODE_B: implMask = MASK_P1_MODE;
      SLOT_P2, SLOT_PORT2_OUTPUT_MODE_B: implMask = MASK_P2_LOW;
      SLOT_WATCHDOG_CONTROL: implMask = MASK_WDOG;
      default: implMask = BYTE_ONES;
    endcase
  endfunction : implMask

  // Constant reset contents of each slot
  function automatic logic [7:0] resetVal(input logic [4:0] slot);
    resetVal = (slot == SLOT_SP) ? SP_RESET : BYTE_ZERO;
  endfunction : resetVal

  // Slots that also answer single-bit access
  function automatic logic isBitReg(input logic [4:0] slot);
    isBitReg = (slot == SLOT_P1) || (slot == SLOT_P2) || (slot == SLOT_TIMER_CONTROL) ||
      (slot == SLOT_SERIAL_CONTROL) || (slot == SLOT_PSW);
  endfunction : isBitReg

endpackage : sfrm_pkg

// [rtl/sfrm_bit_merge.sv]
`timescale 1ns/1ps
// Byte or single-bit write merged into one register image
module sfrm_bit_merge (
  input wire logic [7:0] oldByte,
  input wire logic byteWrite,
  input wire logic [7:0] byteData,
  input wire logic bitWrite,
  input wire logic [2:0] bitIndex,
  input wire logic bitValue,
  input wire logic [7:0] mask,
  output logic [7:0] newByte
);

  // ----------------------------------------------------------------
  // Merge
  // ----------------------------------------------------------------
  // Byte write wins over a bit write in the same cycle
  always_comb begin
    newByte = oldByte;
    if (byteWrite) begin
      newByte = byteData;
    end else if (bitWrite) begin
      newByte[bitIndex] = bitValue;
    end
    newByte = newByte & mask;
  end

endmodule : sfrm_bit_merge

// [rtl/sfrm_power_flags.sv]
`timescale 1ns/1ps
// Brownout and power-on flags, kept only by the power-on reset
module sfrm_power_flags (
  input wire logic clk,
  input wire logic nPor,
  input wire logic brownoutAsync,
  input wire logic clrBrownout,
  input wire logic clrPowerOn,
  output logic brownoutFlag,
  output logic powerOnFlag
);

  typedef struct packed {
    logic bodMeta;
    logic bodSync;
    logic brownout_flag;
    logic power_on_flag;
  } sfrm_flags_s;

  sfrm_flags_s r;
  sfrm_flags_s next_r;

  // ----------------------------------------------------------------
  // Flag logic
  // ----------------------------------------------------------------
  // Brownout synchronised; set wins over a software clear
  always_comb begin
    next_r = r;
    next_r.bodMeta = brownoutAsync;
    next_r.bodSync = r.bodMeta;
    next_r.brownout_flag = r.bodSync | (r.brownout_flag & ~clrBrownout);
    next_r.power_on_flag = r.power_on_flag & ~clrPowerOn;
  end

  // System reset does not reach here, only power-on
  always_ff @(posedge clk or negedge nPor) begin
    if (!nPor) begin
      r <= '{bodMeta: 1'b0, bodSync: 1'b0, brownout_flag: 1'b1, power_on_flag: 1'b1};
    end else begin
      r <= next_r;
    end
  end

  assign brownoutFlag = r.brownout_flag;
  assign powerOnFlag = r.power_on_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_BOF_SET: assert property (@(posedge clk) disable iff (!nPor)
    r.bodSync |=> brownoutFlag) else $error("brownout flag not set by event");
  AST_FLAGS_HELD: assert property (@(posedge clk) disable iff (!nPor)
    (!clrBrownout && !clrPowerOn) |=> (brownoutFlag >= $past(brownoutFlag)) &&
    (powerOnFlag == $past(powerOnFlag))) else $error("cause flag lost without clear");
  AST_POF_CLEAR_ONLY: assert property (@(posedge clk) disable iff (!nPor)
    $fell(powerOnFlag) |-> $past(clrPowerOn)) else $error("power-on flag dropped by itself");

endmodule : sfrm_power_flags

// [rtl/sfrm_reg_bank.sv]
`timescale 1ns/1ps
// Special function register bank: ports, power, timers, serial, watchdog
module sfrm_reg_bank #(
  parameter logic [7:0] WDOG_AFTER_WDRESET = sfrm_pkg::WATCHDOG_CONTROL_DEF_WDRESET,
  parameter logic [7:0] WDOG_AFTER_ENABLED = sfrm_pkg::WATCHDOG_CONTROL_DEF_ENABLED,
  parameter logic [7:0] WDOG_AFTER_DISABLED = sfrm_pkg::WATCHDOG_CONTROL_DEF_DISABLED
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic nPor,
  input wire logic brownoutAsync,
  input wire logic portResetHigh,
  input wire logic wdResetCause,
  input wire logic wdEnabled,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  output logic sfrRdValid,
  input wire logic [7:0] bitAddr,
  input wire logic bitWrEn,
  input wire logic bitWrVal,
  output logic bitRdData,
  input wire logic [7:0] timerCtrlSet,
  input wire logic [7:0] serialCtrlSet,
  input wire logic wdOverflowSet,
  input wire logic accParity,
  input wire logic [7:0] serialRxData,
  output logic [7:0] stackPointer,
  output logic [7:0] powerCtrl,
  output logic [7:0] port0ModeA,
  output logic [7:0] port0ModeB,
  output logic [7:0] port1Latch,
  output logic [7:0] port1ModeA,
  output logic [7:0] port1ModeB,
  output logic [7:0] port2Latch,
  output logic [7:0] port2ModeMisc,
  output logic [7:0] port2ModeB,
  output logic [7:0] port0InputDisable,
  output logic [7:0] timerCtrl,
  output logic [3:0] timer0Mode,
  output logic [3:0] timer1Mode,
  output logic [15:0] timer0Count,
  output logic [15:0] timer1Count,
  output logic [7:0] serialCtrl,
  output logic [7:0] serialTxData,
  output logic serialTxStrobe,
  output logic [7:0] serialOwnAddr,
  output logic [7:0] serialAddrMask,
  output logic [7:0] programStatus,
  output logic [7:0] watchdogCtrl,
  output logic feedStrobe,
  output logic [7:0] feedByte
);

  // Reset values must fit the implemented watchdog control bits
  if (((WDOG_AFTER_WDRESET | WDOG_AFTER_ENABLED | WDOG_AFTER_DISABLED) &
      ~sfrm_pkg::MASK_WDOG) != sfrm_pkg::BYTE_ZERO) begin : gBadWdog
    $error("watchdog control reset value uses unimplemented bits");
  end

  typedef struct packed {
    sfrm_pkg::sfrm_phase_e phase;
    logic [sfrm_pkg::NUM_SLOTS-1:0][7:0] bank;
    logic [7:0] rdData;
    logic rdValid;
    logic bitRd;
    logic feed;
    logic txStrobe;
  } sfrm_state_s;

  sfrm_state_s r;
  sfrm_state_s next_r;

  logic [4:0] byteSlot;
  logic [4:0] bitSlot;
  logic byteHit;
  logic bitHit;
  logic [4:0] tgtSlot;
  logic [7:0] mergedByte;
  logic brownoutFlag;
  logic powerOnFlag;
  logic clrBrownout;
  logic clrPowerOn;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Bit addresses from 80h up map onto bytes on eight-byte boundaries
  assign byteSlot = sfrm_pkg::slotOf(sfrAddr);
  assign bitSlot = sfrm_pkg::slotOf({bitAddr[7:3], 3'b000});
  assign byteHit = sfrWrEn && (byteSlot != sfrm_pkg::SLOT_NONE);
  assign bitHit = bitWrEn && bitAddr[7] && sfrm_pkg::isBitReg(bitSlot);
  assign tgtSlot = byteHit ? byteSlot : bitSlot;

  // Power control cause flags: writing a zero clears them
  assign clrBrownout = byteHit && (byteSlot == sfrm_pkg::SLOT_POWER_CONTROL) &&
    (r.phase == sfrm_pkg::ST_RUN) && !sfrWrData[sfrm_pkg::POWER_CONTROL_BOF_BIT];
  assign clrPowerOn = byteHit && (byteSlot == sfrm_pkg::SLOT_POWER_CONTROL) &&
    (r.phase == sfrm_pkg::ST_RUN) && !sfrWrData[sfrm_pkg::POWER_CONTROL_POF_BIT];

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  sfrm_bit_merge uMerge (
    .oldByte(r.bank[tgtSlot]),
    .byteWrite(byteHit),
    .byteData(sfrWrData),
    .bitWrite(bitHit),
    .bitIndex(bitAddr[2:0]),
    .bitValue(bitWrVal),
    .mask(sfrm_pkg::implMask(tgtSlot)),
    .newByte(mergedByte)
  );

  sfrm_power_flags uFlags (
    .clk(clk),
    .nPor(nPor),
    .brownoutAsync(brownoutAsync),
    .clrBrownout(clrBrownout),
    .clrPowerOn(clrPowerOn),
    .brownoutFlag(brownoutFlag),
    .powerOnFlag(powerOnFlag)
  );

  // ----------------------------------------------------------------
  // Read view
  // ----------------------------------------------------------------
  // Feed reads zero, buffer reads receive data, flags come from outside
  function automatic logic [7:0] readView(input logic [4:0] slot);
    unique case (slot)
      sfrm_pkg::SLOT_NONE, sfrm_pkg::SLOT_WATCHDOG_FEED: readView = sfrm_pkg::BYTE_ZERO;
      sfrm_pkg::SLOT_SERIAL_BUFFER: readView = serialRxData;
      sfrm_pkg::SLOT_POWER_CONTROL: begin
        readView = r.bank[slot];
        readView[sfrm_pkg::POWER_CONTROL_BOF_BIT] = brownoutFlag;
        readView[sfrm_pkg::POWER_CONTROL_POF_BIT] = powerOnFlag;
      end
      default: readView = r.bank[slot] & sfrm_pkg::implMask(slot);
    endcase
  endfunction : readView

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] bitView;
    bitView = readView(bitSlot);
    next_r = r;
    next_r.feed = 1'b0;
    next_r.txStrobe = 1'b0;
    next_r.rdValid = sfrRdEn;
    next_r.rdData = sfrRdEn ? readView(byteSlot) : r.rdData;
    next_r.bitRd = (bitAddr[7] && sfrm_pkg::isBitReg(bitSlot)) ?
      bitView[bitAddr[2:0]] : 1'b0;
    unique case (r.phase)
      sfrm_pkg::ST_INIT: begin
        // First edge after release: cause-dependent contents
        next_r.bank[sfrm_pkg::SLOT_P1] = {8{portResetHigh}};
        next_r.bank[sfrm_pkg::SLOT_P2] = {8{portResetHigh}} & sfrm_pkg::MASK_P2_LOW;
        if (wdResetCause) begin
          next_r.bank[sfrm_pkg::SLOT_WATCHDOG_CONTROL] = WDOG_AFTER_WDRESET;
        end else if (wdEnabled) begin
          next_r.bank[sfrm_pkg::SLOT_WATCHDOG_CONTROL] = WDOG_AFTER_ENABLED;
        end else begin
          next_r.bank[sfrm_pkg::SLOT_WATCHDOG_CONTROL] = WDOG_AFTER_DISABLED;
        end
        next_r.phase = sfrm_pkg::ST_RUN;
      end
      sfrm_pkg::ST_RUN: begin
        if (byteHit || bitHit) begin
          next_r.bank[tgtSlot] = mergedByte;
        end
        if (byteHit && (byteSlot == sfrm_pkg::SLOT_WATCHDOG_FEED)) begin
          next_r.feed = 1'b1;
        end
        if (byteHit && (byteSlot == sfrm_pkg::SLOT_SERIAL_BUFFER)) begin
          next_r.txStrobe = 1'b1;
        end
        // Hardware events win over software clears
        next_r.bank[sfrm_pkg::SLOT_TIMER_CONTROL] = next_r.bank[sfrm_pkg::SLOT_TIMER_CONTROL] | timerCtrlSet;
        next_r.bank[sfrm_pkg::SLOT_SERIAL_CONTROL] = next_r.bank[sfrm_pkg::SLOT_SERIAL_CONTROL] | serialCtrlSet;
        if (wdOverflowSet) begin
          next_r.bank[sfrm_pkg::SLOT_WATCHDOG_CONTROL][sfrm_pkg::WATCHDOG_CONTROL_OVF_BIT] = 1'b1;
        end
      end
    endcase
    // Parity follows the accumulator at all times
    next_r.bank[sfrm_pkg::SLOT_PSW][sfrm_pkg::PSW_PARITY_BIT] = accParity;
  end

  // State register; power control low bits clear on every reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r.phase <= sfrm_pkg::ST_INIT;
      for (int i = 0; i < sfrm_pkg::NUM_SLOTS; i++) begin
        r.bank[i] <= sfrm_pkg::resetVal(5'(i));
      end
      r.rdData <= sfrm_pkg::BYTE_ZERO;
      r.rdValid <= 1'b0;
      r.bitRd <= 1'b0;
      r.feed <= 1'b0;
      r.txStrobe <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfrRdData = r.rdData;
  assign sfrRdValid = r.rdValid;
  assign bitRdData = r.bitRd;
  assign stackPointer = r.bank[sfrm_pkg::SLOT_SP];
  // Cause flags merged in; a process so that flag changes reach the port
  always_comb begin
    powerCtrl = readView(sfrm_pkg::SLOT_POWER_CONTROL);
  end
  assign port0ModeA = r.bank[sfrm_pkg::SLOT_PORT0_OUTPUT_MODE_A];
  assign port0ModeB = r.bank[sfrm_pkg::SLOT_PORT0_OUTPUT_MODE_B];
  assign port1Latch = r.bank[sfrm_pkg::SLOT_P1];
  assign port1ModeA = r.bank[sfrm_pkg::SLOT_PORT1_OUTPUT_MODE_A];
  assign port1ModeB = r.bank[sfrm_pkg::SLOT_PORT1_OUTPUT_MODE_B];
  assign port2Latch = r.bank[sfrm_pkg::SLOT_P2];
  assign port2ModeMisc = r.bank[sfrm_pkg::SLOT_PORT2_MODE_A_AND_MISC];
  assign port2ModeB = r.bank[sfrm_pkg::SLOT_PORT2_OUTPUT_MODE_B];
  assign port0InputDisable = r.bank[sfrm_pkg::SLOT_PORT0_INPUT_DISABLE];
  assign timerCtrl = r.bank[sfrm_pkg::SLOT_TIMER_CONTROL];
  // Upper nibble drives timer 1, lower nibble timer 0
  assign timer1Mode = r.bank[sfrm_pkg::SLOT_TIMER_MODE][sfrm_pkg::TIMER_MODE_T1_LSB +: 4];
  assign timer0Mode = r.bank[sfrm_pkg::SLOT_TIMER_MODE][3:0];
  assign timer0Count = {r.bank[sfrm_pkg::SLOT_TH0], r.bank[sfrm_pkg::SLOT_TL0]};
  assign timer1Count = {r.bank[sfrm_pkg::SLOT_TH1], r.bank[sfrm_pkg::SLOT_TL1]};
  assign serialCtrl = r.bank[sfrm_pkg::SLOT_SERIAL_CONTROL];
  assign serialTxData = r.bank[sfrm_pkg::SLOT_SERIAL_BUFFER];
  assign serialTxStrobe = r.txStrobe;
  assign serialOwnAddr = r.bank[sfrm_pkg::SLOT_SERIAL_OWN_ADDRESS];
  assign serialAddrMask = r.bank[sfrm_pkg::SLOT_SERIAL_ADDRESS_MASK];
  assign programStatus = r.bank[sfrm_pkg::SLOT_PSW];
  assign watchdogCtrl = r.bank[sfrm_pkg::SLOT_WATCHDOG_CONTROL];
  assign feedStrobe = r.feed;
  assign feedByte = r.bank[sfrm_pkg::SLOT_WATCHDOG_FEED];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic runNow;
  assign runNow = (r.phase == sfrm_pkg::ST_RUN);

  sequence s_initRelease;
    !runNow ##1 runNow;
  endsequence

  sequence s_tmodWrite;
    runNow && sfrWrEn && (sfrAddr == sfrm_pkg::ADDR_TIMER_MODE);
  endsequence

  AST_UNIMPL_ZERO: assert property (
    sfrRdEn && (sfrAddr == sfrm_pkg::ADDR_P2) |=> sfrRdValid && (sfrRdData[7:2] == 6'h00))
    else $error("unimplemented port 2 bits read nonzero");
  AST_PORT_RESET_LEVEL: assert property (
    s_initRelease |-> (port1Latch == {8{$past(portResetHigh)}}) &&
    (port2Latch == ({8{$past(portResetHigh)}} & sfrm_pkg::MASK_P2_LOW)))
    else $error("port latches not loaded from reset level bit");
  AST_POWER_CONTROL_LOW_CLEAR: assert property (
    s_initRelease |-> (powerCtrl & sfrm_pkg::MASK_POWER_CONTROL_CORE) == sfrm_pkg::BYTE_ZERO)
    else $error("power control low bits not cleared by reset");
  AST_WATCHDOG_CONTROL_CAUSE: assert property (
    s_initRelease |-> watchdogCtrl == ($past(wdResetCause) ? WDOG_AFTER_WDRESET :
    ($past(wdEnabled) ? WDOG_AFTER_ENABLED : WDOG_AFTER_DISABLED)))
    else $error("watchdog control reset value does not match cause");
  AST_BIT_WRITE_PSW: assert property (
    runNow && bitWrEn && !sfrWrEn && (bitAddr[7:3] == sfrm_pkg::ADDR_PSW[7:3]) &&
    (bitAddr[2:0] != 3'h0) |=> programStatus[$past(bitAddr[2:0])] == $past(bitWrVal))
    else $error("program status bit write lost");
  AST_TIMER_MODE_SPLIT: assert property (
    s_tmodWrite |=> (timer1Mode == $past(sfrWrData[7:4])) &&
    (timer0Mode == $past(sfrWrData[3:0])))
    else $error("timer mode fields not split as written");
  AST_FEED_STROBE: assert property (
    runNow && sfrWrEn && (sfrAddr == sfrm_pkg::ADDR_WATCHDOG_FEED) |=> feedStrobe &&
    (feedByte == $past(sfrWrData)))
    else $error("feed write not passed on");
  AST_FEED_READ_ZERO: assert property (
    sfrRdEn && (sfrAddr == sfrm_pkg::ADDR_WATCHDOG_FEED) |=> sfrRdData == sfrm_pkg::BYTE_ZERO)
    else $error("feed register read nonzero");

endmodule : sfrm_reg_bank

// [verification/sfr_map_reset_flags_test.sv]
`timescale 1ns/1ps
module sfr_map_reset_flags_test;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic nPor = 1'b0;
  logic brownoutAsync = 1'b0;
  logic portResetHigh = 1'b1;
  logic wdResetCause = 1'b1;
  logic wdEnabled = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrRdEn = 1'b0;
  logic [7:0] bitAddr = 8'h00;
  logic bitWrEn = 1'b0;
  logic bitWrVal = 1'b0;
  logic accParity = 1'b1;
  logic [7:0] tcSet = 8'h00;
  logic wdOvf = 1'b0;
  logic [7:0] stackPointer, serialTxData, timerCtrl, serialCtrl;
  logic serialTxStrobe;
  logic [7:0] sfrRdData, powerCtrl, port0ModeA, port1Latch, port2Latch;
  logic [7:0] programStatus, watchdogCtrl, feedByte, rdVal;
  logic [3:0] timer0Mode, timer1Mode;
  logic sfrRdValid, bitRdData, feedStrobe;
  logic [7:0] tAddr [4] = '{8'h91, 8'ha5, 8'hc1, 8'ha0};
  logic [7:0] tExp [4] = '{8'hd3, 8'h03, 8'h00, 8'h03};
  int errTotal = 0;
  int checked = 0;

  sfrm_reg_bank dut_u (.clk(clk), .nrst(nrst), .nPor(nPor), .brownoutAsync(brownoutAsync),
    .portResetHigh(portResetHigh), .wdResetCause(wdResetCause), .wdEnabled(wdEnabled),
    .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
    .sfrRdData(sfrRdData), .sfrRdValid(sfrRdValid), .bitAddr(bitAddr), .bitWrEn(bitWrEn),
    .bitWrVal(bitWrVal), .bitRdData(bitRdData), .timerCtrlSet(tcSet), .serialCtrlSet(8'h00),
    .wdOverflowSet(wdOvf), .accParity(accParity), .serialRxData(8'h3c),
    .stackPointer(stackPointer),
    .powerCtrl(powerCtrl), .port0ModeA(port0ModeA), .port0ModeB(), .port1Latch(port1Latch),
    .port1ModeA(), .port1ModeB(), .port2Latch(port2Latch), .port2ModeMisc(), .port2ModeB(),
    .port0InputDisable(), .timerCtrl(timerCtrl), .timer0Mode(timer0Mode),
    .timer1Mode(timer1Mode), .timer0Count(), .timer1Count(), .serialCtrl(serialCtrl),
    .serialTxData(serialTxData), .serialTxStrobe(serialTxStrobe),
    .serialOwnAddr(), .serialAddrMask(), .programStatus(programStatus),
    .watchdogCtrl(watchdogCtrl), .feedStrobe(feedStrobe), .feedByte(feedByte));

  // Free running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic results();
    if (errTotal == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // System reset with the sampled configuration levels
  task automatic doReset(input logic prh, input logic cause, input logic en);
    @(posedge clk);
    #1 nrst = 1'b0;
    portResetHigh = prh;
    wdResetCause = cause;
    wdEnabled = en;
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : doReset

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(posedge clk);
    #1 sfrWrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(posedge clk);
    #1 sfrRdEn = 1'b0;
    chk("read valid", {7'h00, sfrRdValid}, 8'h01);
    d = sfrRdData;
  endtask : rd

  task automatic bitWr(input logic [7:0] a, input logic v);
    bitAddr = a;
    bitWrVal = v;
    bitWrEn = 1'b1;
    @(posedge clk);
    #1 bitWrEn = 1'b0;
  endtask : bitWr

  // One idle edge between two requests on the same strobe
  task automatic gap();
    @(posedge clk);
    #1;
  endtask : gap

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    #1 nPor = 1'b1;
    doReset(1'b1, 1'b1, 1'b0);
    chk("port1 latch", port1Latch, 8'hff);
    chk("port2 latch", port2Latch, 8'h03);
    chk("wdog ctrl", watchdogCtrl, sfrm_pkg::WATCHDOG_CONTROL_DEF_WDRESET);
    chk("cause flags", {6'h00, powerCtrl[5:4]}, 8'h03);
    rd(sfrm_pkg::ADDR_SP, rdVal);
    chk("stack pointer", rdVal, 8'h07);
    chk("stack pointer port", stackPointer, 8'h07);
    // Flags survive reset, low power bits clear
    wr(sfrm_pkg::ADDR_POWER_CONTROL, 8'h3f);
    doReset(1'b0, 1'b0, 1'b1);
    chk("power ctrl", {2'b00, powerCtrl[5:0]}, 8'h30);
    chk("port1 latch", port1Latch, 8'h00);
    chk("wdog ctrl", watchdogCtrl, sfrm_pkg::WATCHDOG_CONTROL_DEF_ENABLED);
    doReset(1'b0, 1'b0, 1'b0);
    chk("wdog ctrl", watchdogCtrl, sfrm_pkg::WATCHDOG_CONTROL_DEF_DISABLED);
    // Brownout event after flags cleared
    wr(sfrm_pkg::ADDR_POWER_CONTROL, 8'h00);
    chk("cause flags", {6'h00, powerCtrl[5:4]}, 8'h00);
    brownoutAsync = 1'b1;
    for (int i = 0; i < 8 && powerCtrl[5] !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    brownoutAsync = 1'b0;
    chk("cause flags", {6'h00, powerCtrl[5:4]}, 8'h02);
    wr(sfrm_pkg::ADDR_TIMER_MODE, 8'ha5);
    chk("timer modes", {timer1Mode, timer0Mode}, 8'ha5);
    // Unimplemented bits and unmapped place
    gap();
    for (int i = 0; i < 4; i++) begin
      wr(tAddr[i], 8'hff);
      rd(tAddr[i], rdVal);
      chk("masked byte", rdVal, tExp[i]);
    end
    gap();
    rd(sfrm_pkg::ADDR_SERIAL_BUFFER, rdVal);
    chk("serial rx", rdVal, 8'h3c);
    wr(sfrm_pkg::ADDR_SERIAL_BUFFER, 8'h69);
    chk("tx strobe", {7'h00, serialTxStrobe}, 8'h01);
    chk("tx data", serialTxData, 8'h69);
    // Single-bit access
    bitWr(8'hd5, 1'b1);
    chk("status word", programStatus, 8'h21);
    gap();
    bitWr(8'h84, 1'b1);
    chk("port0 mode", port0ModeA, 8'h00);
    bitAddr = 8'hd5;
    @(posedge clk);
    #1 chk("bit read", {7'h00, bitRdData}, 8'h01);
    bitWr(8'h9c, 1'b1);
    chk("serial ctrl", serialCtrl, 8'h10);
    // Hardware set against a bit clear in the same cycle
    gap();
    tcSet = 8'h80;
    bitWr(8'h8f, 1'b0);
    tcSet = 8'h00;
    chk("timer ctrl", timerCtrl, 8'h80);
    // Watchdog overflow flag set by hardware on top of a written value
    wr(sfrm_pkg::ADDR_WATCHDOG_CONTROL, 8'h01);
    wdOvf = 1'b1;
    @(posedge clk);
    #1 wdOvf = 1'b0;
    chk("wdog ctrl", watchdogCtrl, 8'h21);
    // Watchdog feed bytes
    wr(sfrm_pkg::ADDR_WATCHDOG_FEED, 8'h5a);
    chk("feed strobe", {7'h00, feedStrobe}, 8'h01);
    chk("feed byte", feedByte, 8'h5a);
    rd(sfrm_pkg::ADDR_WATCHDOG_FEED, rdVal);
    chk("feed read", rdVal, 8'h00);
    results();
  end
endmodule : sfr_map_reset_flags_test
